// >>> rtl/byte_lane_access_sequencer.sv
// byte lane access sequencer: splits operands of 1..4 bytes at any byte
// address into even byte, odd byte and even word bus cycles.
// assumes a bus engine that takes one cycle per cyc_ready and returns
// read lanes with rd_valid on the cycle it completes.
// Functional notes
// - 24-bit byte address, 16M locations
// - any size and alignment, never trapped
// - three cycle kinds by enable and lsb
// - every access built from those kinds
// - cycles of one operand back to back
// - cycle count from size and alignment
`timescale 1ns/1ps
`include "lane_seq_params.svh"
module byte_lane_access_sequencer
  import lane_seq_pkg::*;
#(
  parameter int MAX_BYTES = `MAX_BYTES
) (
  input  wire logic                      clk,        // bus clock
  input  wire logic                      rstn,       // async reset, low
  input  wire logic                      op_valid,   // operand request
  output logic                           op_ready,   // request taken
  input  wire op_req_t                   op,         // operand request
  output logic                           op_done,    // operand finished
  output logic [`MAX_BYTES*`BYTE_W-1:0]  op_rdata,   // assembled read data
  output logic                           cyc_valid,  // bus cycle offered
  input  wire logic                      cyc_ready,  // bus cycle taken
  output bus_cycle_t                     cyc,        // bus cycle fields
  output logic [`ADDR_W-1:1]             word_address_lines, // to both banks
  output logic                           byte_select_lsb,    // lower bank sel
  output logic                           upper_lane_enable_n,// upper bank sel
  input  wire logic                      rd_valid,   // read cycle complete
  input  wire logic [`DATA_W-1:0]        muxed_addr_data_lines // read lanes
);
  // refuse operand widths the byte buffers cannot hold
  if (MAX_BYTES < 1 || MAX_BYTES > `MAX_BYTES) begin
    $error("MAX_BYTES out of range");
  end

  seq_state_t                     state, next_state;
  logic [`ADDR_W-1:0]             addr, next_addr;
  logic [`SIZE_W-1:0]             left, next_left;
  logic [`SIZE_W-1:0]             pos, next_pos;
  logic                           wr, next_wr;
  logic [`MAX_BYTES*`BYTE_W-1:0]  wbuf, next_wbuf;
  logic [`MAX_BYTES*`BYTE_W-1:0]  rbuf, next_rbuf;
  logic                           done, next_done;
  logic [`SIZE_W-1:0]             pend, next_pend;
  // reads complete in order, so one tracker follows the oldest
  logic [`SIZE_W-1:0]             rd_pos, next_rd_pos;
  logic                           rd_lo;
  logic                           rd_two;
  logic                           rd_pos_valid;
  logic [`ADDR_W-1:0]             rd_addr, next_rd_addr;
  logic [`SIZE_W-1:0]             rd_left, next_rd_left;

  // picks the cycle kind for the current address and bytes left
  // odd address first aligns the rest to words
  function automatic cycle_kind_t pick(input logic lsb, input logic [`SIZE_W-1:0] n);
    if (lsb)
      return cyc_odd_byte;
    else if (n >= `SIZE_W'(2))
      return cyc_even_word;
    else
      return cyc_even_byte;
  endfunction

  // bytes moved by a cycle kind
  function automatic logic [`SIZE_W-1:0] width_of(input cycle_kind_t k);
    return (k == cyc_even_word) ? `SIZE_W'(2) : `SIZE_W'(1);
  endfunction

  cycle_kind_t        kind;
  logic [`SIZE_W-1:0] step;
  logic [`DATA_W-1:0] lane_wdata;
  // kind encoding
  // idle with no bytes left decodes by addr[0] as even byte or odd byte; pins masked then
  assign kind = pick(addr[0], left);
  assign step = width_of(kind);

  // write lanes: odd byte rides the upper lane, even byte the lower
  assign lane_wdata = (kind == cyc_odd_byte) ?
                      {wbuf[pos*`BYTE_W +: `BYTE_W], `BYTE_W'(0)} :
                      (kind == cyc_even_word) ? wbuf[pos*`BYTE_W +: `DATA_W] :
                      {`BYTE_W'(0), wbuf[pos*`BYTE_W +: `BYTE_W]};

  // enable low selects upper bank
  // one driver for the whole cycle record
  assign cyc = '{word_addr: addr[`ADDR_W-1:1],
                 lsb:       kind[0],
                 upper_n:   kind[1],
                 write:     wr,
                 wdata:     lane_wdata};
  assign word_address_lines  = state == st_run ? cyc.word_addr : '0;
  assign byte_select_lsb     = state == st_run ? cyc.lsb : 1'b0;
  assign upper_lane_enable_n = state == st_run ? cyc.upper_n : `LANE_OFF_N;
  assign cyc_valid = state == st_run;
  // any operand accepted
  // no new operand while reads are still owed
  assign op_ready  = state == st_idle && pend == '0;
  assign op_done   = done;
  assign op_rdata  = rbuf;

  // next state of the sequencer
  always_comb begin
    next_state = state;
    next_addr  = addr;
    next_left  = left;
    next_pos   = pos;
    next_wr    = wr;
    next_wbuf  = wbuf;
    next_rbuf  = rbuf;
    next_done  = 1'b0;
    next_pend  = pend;
    // read lanes land by the byte position of their cycle
    if (rd_valid && pend != '0) begin
      next_pend = pend - `SIZE_W'(1);
    end
    unique case (state)
      st_idle: begin
        // a zero-byte request is taken and dropped
        if (op_valid && op_ready && op.nbytes != '0) begin
          next_state = st_run;
          next_addr  = op.addr;
          next_left  = op.nbytes;
          next_pos   = '0;
          next_wr    = op.write;
          next_wbuf  = op.wdata;
          next_rbuf  = '0;
        end
      end
      st_run: begin
        if (cyc_ready) begin
          next_addr = addr + `ADDR_W'(step);
          next_left = left - step;
          next_pos  = pos + step;
          if (!wr)
            next_pend = next_pend + `SIZE_W'(1);
          if (left == step) begin
            next_state = st_idle;
            next_done  = wr;
          end
        end
      end
    endcase
    if (rd_pos_valid) begin
      next_rbuf[rd_pos*`BYTE_W +: `BYTE_W] = rd_lo ?
        muxed_addr_data_lines[`BYTE_W +: `BYTE_W] : muxed_addr_data_lines[0 +: `BYTE_W];
      // a word read fills two buffer bytes
      if (rd_two)
        next_rbuf[(rd_pos+`SIZE_W'(1))*`BYTE_W +: `BYTE_W] =
          muxed_addr_data_lines[`BYTE_W +: `BYTE_W];
      // last response after the final cycle ends a read
      if (pend == `SIZE_W'(1) && state == st_idle)
        next_done = 1'b1;
    end
  end

  // tracks where the oldest outstanding read lands
  assign rd_pos_valid = rd_valid && pend != '0;
  assign rd_lo  = rd_addr[0];
  assign rd_two = pick(rd_addr[0], rd_left) == cyc_even_word;

  // read position bookkeeping
  always_comb begin
    next_rd_pos  = rd_pos;
    next_rd_addr = rd_addr;
    next_rd_left = rd_left;
    if (state == st_idle && op_valid && op_ready) begin
      next_rd_pos  = '0;
      next_rd_addr = op.addr;
      next_rd_left = op.nbytes;
    end else if (rd_pos_valid) begin
      next_rd_pos  = rd_pos + width_of(pick(rd_addr[0], rd_left));
      next_rd_addr = rd_addr + `ADDR_W'(width_of(pick(rd_addr[0], rd_left)));
      next_rd_left = rd_left - width_of(pick(rd_addr[0], rd_left));
    end
  end

  // registers of the sequencer
  // async clear loads constants only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state   <= st_idle;
      addr    <= '0;
      left    <= '0;
      pos     <= '0;
      wr      <= 1'b0;
      wbuf    <= '0;
      rbuf    <= '0;
      done    <= 1'b0;
      pend    <= '0;
      rd_pos  <= '0;
      rd_addr <= '0;
      rd_left <= '0;
    end else begin
      state   <= next_state;
      addr    <= next_addr;
      left    <= next_left;
      pos     <= next_pos;
      wr      <= next_wr;
      wbuf    <= next_wbuf;
      rbuf    <= next_rbuf;
      done    <= next_done;
      pend    <= next_pend;
      rd_pos  <= next_rd_pos;
      rd_addr <= next_rd_addr;
      rd_left <= next_rd_left;
    end
  end
endmodule

// >>> rtl/lane_seq_params.svh
// constants for the byte lane access sequencer
// assumes inclusion by the sequencer package and module only
`ifndef LANE_SEQ_PARAMS_SVH
`define LANE_SEQ_PARAMS_SVH
`define ADDR_W        24
`define DATA_W        16
`define SIZE_W        3
`define MAX_BYTES     4
`define BYTE_W        8
`define LANE_ON_N     1'b0
`define LANE_OFF_N    1'b1
`endif

// >>> rtl/lane_seq_pkg.sv
// types for the byte lane access sequencer
// assumes lane_seq_params.svh is on the include path
`include "lane_seq_params.svh"
package lane_seq_pkg;
  typedef enum logic [1:0] {
    cyc_even_byte = 2'b10,
    cyc_odd_byte  = 2'b01,
    cyc_even_word = 2'b00
  } cycle_kind_t;

  typedef struct packed {
    logic [`ADDR_W-1:0]             addr;
    logic [`SIZE_W-1:0]             nbytes;
    logic                           write;
    logic [`MAX_BYTES*`BYTE_W-1:0]  wdata;
  } op_req_t;

  typedef struct packed {
    logic [`ADDR_W-1:1] word_addr;
    logic               lsb;
    logic               upper_n;
    logic               write;
    logic [`DATA_W-1:0] wdata;
  } bus_cycle_t;

  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_run  = 1'b1
  } seq_state_t;
endpackage

// >>> test/lane_seq_checker.sv
// port checker for the byte lane sequencer
// assumes binding onto the sequencer top module
`timescale 1ns/1ps
module lane_seq_checker import lane_seq_pkg::*; (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        op_valid,
  input wire logic        op_ready,
  input wire op_req_t     op,
  input wire logic        op_done,
  input wire logic        cyc_valid,
  input wire logic        cyc_ready,
  input wire bus_cycle_t  cyc,
  input wire logic [23:1] word_address_lines,
  input wire logic        byte_select_lsb,
  input wire logic        upper_lane_enable_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // cycle kinds and bank pins
  property p_kind; cyc_valid |-> {cyc.upper_n, cyc.lsb} != 2'b11; endproperty
  a_kind: assert property (p_kind) else $error("bad kind"); // three kinds
  property p_pins; cyc_valid |-> word_address_lines == cyc.word_addr
    && byte_select_lsb == cyc.lsb && upper_lane_enable_n == cyc.upper_n; endproperty
  a_pins: assert property (p_pins) else $error("bad pins"); // shared word lines
  property p_idle; !cyc_valid |-> upper_lane_enable_n && !byte_select_lsb; endproperty
  a_idle: assert property (p_idle) else $error("lane on"); // upper bank off
  property p_start; op_valid && op_ready && op.nbytes != 0 |=> cyc_valid; endproperty
  a_start: assert property (p_start) else $error("no cycle"); // cycle follows op
  property p_hold; cyc_valid && !cyc_ready |=> cyc_valid && $stable(cyc); endproperty
  a_hold: assert property (p_hold) else $error("cycle moved"); // cycle stands
  property p_odd; cyc_valid && cyc_ready && cyc.lsb ##1 cyc_valid
    |-> cyc.word_addr == $past(cyc.word_addr) + 1'b1 && !cyc.lsb; endproperty
  a_odd: assert property (p_odd) else $error("bad split"); // odd then even
  property p_done; op_done |=> !op_done; endproperty
  a_done: assert property (p_done) else $error("long done"); // single pulse
  property p_gap; cyc_valid && cyc_ready && cyc.write |=> cyc_valid || op_done; endproperty
  a_gap: assert property (p_gap) else $error("gap in operand"); // back to back
  property p_fin; op_valid && op_ready && op.nbytes != 0 |-> ##[2:100] op_done; endproperty
  a_fin: assert property (p_fin) else $error("op stuck"); // never trapped
endmodule
bind byte_lane_access_sequencer lane_seq_checker u_chk (.*);

// >>> test/lane_bank_model.sv
// two byte banks on the far side of the sequencer
// assumes reads answered one cycle after a cycle is taken
`timescale 1ns/1ps
module lane_bank_model import lane_seq_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        stall,
  input  wire logic        cyc_valid,
  output logic             cyc_ready,
  input  wire bus_cycle_t  cyc,
  input  wire logic [23:1] word_address_lines,
  input  wire logic        byte_select_lsb,
  input  wire logic        upper_lane_enable_n,
  output logic             rd_valid,
  output logic [15:0]      muxed_addr_data_lines
);
  logic [7:0] lo [256];
  logic [7:0] hi [256];
  logic [7:0] junk, q_lo, q_hi;
  // released lanes toggle every cycle
  assign cyc_ready = !stall;
  assign muxed_addr_data_lines = rd_valid ? {q_hi, q_lo} : {junk, ~junk};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_valid <= 1'b0;
      junk     <= 8'hA5;
    end else begin
      junk     <= ~junk;
      rd_valid <= cyc_valid && cyc_ready && !cyc.write;
      if (cyc_valid && cyc_ready) begin
        if (!byte_select_lsb && cyc.write) lo[word_address_lines[8:1]] <= cyc.wdata[7:0];
        if (!upper_lane_enable_n && cyc.write) hi[word_address_lines[8:1]] <= cyc.wdata[15:8];
        q_lo <= byte_select_lsb ? junk : lo[word_address_lines[8:1]];
        q_hi <= upper_lane_enable_n ? junk : hi[word_address_lines[8:1]];
      end
    end
  end
endmodule

// >>> test/test_byte_lane_access_sequencer.sv
// self-checking bench for the byte lane sequencer
// assumes the bank model answers on the far side
`timescale 1ns/1ps
module test_byte_lane_access_sequencer;
  import lane_seq_pkg::*;
  logic clk = 0, rstn = 0, op_valid = 0, stall = 0;
  logic op_ready, op_done, cyc_valid, cyc_ready, rd_valid;
  logic byte_select_lsb, upper_lane_enable_n;
  op_req_t     op = '0;
  bus_cycle_t  cyc;
  logic [31:0] op_rdata;
  logic [23:1] word_address_lines;
  logic [15:0] muxed_addr_data_lines;
  logic [7:0]  mem [512];
  logic [7:0]  lfsr = 8'h38;
  logic [23:0] a;
  logic [2:0]  n;
  int error_cnt = 0, num_checks = 0, cyc_cnt = 0, tmo = 0;
  byte_lane_access_sequencer u_dut (.*);
  lane_bank_model u_banks (.*);
  initial forever #20 clk = ~clk;
  // stall pattern, cycle count, timeout
  always @(posedge clk) begin
    stall <= lfsr[0] & ~stall;
    if (cyc_valid && cyc_ready) cyc_cnt++;
    tmo++;
    if (tmo > 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  function automatic logic [7:0] step(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic int ncyc(logic [23:0] ad, int nb);
    int f = int'(ad[0]);
    return f + (nb - f) / 2 + (nb - f) % 2;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task automatic do_op(input logic w, input logic [31:0] d);
    int c0, k;
    logic [31:0] e;
    c0 = cyc_cnt;
    e = '0;
    @(posedge clk);
    op_valid <= 1'b1;
    op <= '{a, n, w, d};
    @(posedge clk);
    op_valid <= 1'b0;
    for (k = 0; k < 200 && op_done !== 1'b1; k++) @(negedge clk);
    chk(32'(op_done), 32'h1); // operand completes
    for (k = 0; k < n; k++) begin
      if (w) mem[9'(a + k)] = d[8*k +: 8];
      e[8*k +: 8] = mem[9'(a + k)];
    end
    if (!w) chk(op_rdata & ~(32'hFFFFFFFF << 8 * n), e); // any alignment data
    chk(32'(cyc_cnt - c0), 32'(ncyc(a, n))); // cycle count
  endtask
  // every size at odd and even start, then random
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      lfsr = step(lfsr);
      a = i < 8 ? 24'h000101 + 24'(i) : {lfsr, step(lfsr), ~lfsr};
      n = i < 8 ? 3'(i / 2 + 1) : 3'(lfsr % 4 + 1);
      do_op(1'b1, {lfsr, step(lfsr), ~lfsr, 8'(i)}); // write split
      do_op(1'b0, 32'h0); // read back
    end
    report_and_stop();
  end
endmodule
